// file: verilog/ggss_pkg.sv
// package for the gain group switch selector
// assumes a 250 MHz clock and a 32-bit apb register bus
package ggss_pkg;
    // ------------------------------------------------------------
    // register byte offsets
    // ------------------------------------------------------------
    localparam logic [7:0] OFF_POS_MODE   = 8'h00;
    localparam logic [7:0] OFF_POS_DELAY  = 8'h04;
    localparam logic [7:0] OFF_POS_GRADE  = 8'h08;
    localparam logic [7:0] OFF_POS_HYST   = 8'h0C;
    localparam logic [7:0] OFF_POS_TIME   = 8'h10;
    localparam logic [7:0] OFF_SPD_MODE   = 8'h14;
    localparam logic [7:0] OFF_SPD_DELAY  = 8'h18;
    localparam logic [7:0] OFF_SPD_GRADE  = 8'h1C;
    localparam logic [7:0] OFF_SPD_HYST   = 8'h20;
    localparam logic [7:0] OFF_TRQ_MODE   = 8'h24;
    localparam logic [7:0] OFF_TRQ_DELAY  = 8'h28;
    localparam logic [7:0] OFF_TRQ_GRADE  = 8'h2C;
    localparam logic [7:0] OFF_TRQ_HYST   = 8'h30;
    localparam logic [7:0] OFF_OBS_EN     = 8'h34;
    localparam logic [7:0] OFF_OBS_CUT    = 8'h38;
    localparam logic [7:0] OFF_OBS_PHASE  = 8'h3C;
    localparam logic [7:0] OFF_OBS_INERT  = 8'h40;
    localparam logic [7:0] OFF_CTRL       = 8'h44;
    localparam logic [7:0] OFF_STATUS     = 8'h48;
    localparam logic [7:0] OFF_ACTIVE     = 8'h4C;
    localparam int         NREG           = 19;
    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [15:0] RST_POS_DELAY = 16'h0032;
    localparam logic [15:0] RST_POS_GRADE = 16'h0032;
    localparam logic [15:0] RST_POS_HYST  = 16'h0021;
    localparam logic [15:0] RST_POS_TIME  = 16'h0021;
    localparam logic [15:0] RST_OBS_CUT   = 16'h0064;
    localparam logic [15:0] RST_OBS_INERT = 16'h03E8;
    localparam logic [15:0] RST_ZERO      = 16'h0000;
    // ------------------------------------------------------------
    // ranges
    // ------------------------------------------------------------
    localparam logic [15:0] MAX_DELAY     = 16'h03E8;
    localparam logic [15:0] MAX_GRADE     = 16'h4E20;
    localparam logic [15:0] MAX_POS_MODE  = 16'h000A;
    localparam logic [15:0] MAX_SPD_MODE  = 16'h0005;
    localparam logic [15:0] MAX_TRQ_MODE  = 16'h0003;
    localparam logic [15:0] MAX_OBS_EN    = 16'h0002;
    localparam logic [15:0] MAX_OBS_CUT   = 16'h01F4;
    localparam logic [15:0] MAX_OBS_PHASE = 16'h2710;
    localparam logic [15:0] MAX_OBS_INERT = 16'h2710;
    // ------------------------------------------------------------
    // timing: one delay step is 0.1 ms
    // ------------------------------------------------------------
    localparam int TICK_NS      = 100000;
    localparam int CLK_NS       = 4;
    localparam int TICK_CYCLES  = TICK_NS / CLK_NS;
    // ------------------------------------------------------------
    // control modes and switchover mode codes
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        GGSS_CM_POS = 2'b00,
        GGSS_CM_SPD = 2'b01,
        GGSS_CM_TRQ = 2'b10
    } ggss_ctrl_mode_t;
    localparam logic [3:0] MD_FIX1   = 4'h0;
    localparam logic [3:0] MD_FIX2   = 4'h1;
    localparam logic [3:0] MD_INPUT  = 4'h2;
    localparam logic [3:0] MD_TORQUE = 4'h3;
    localparam logic [3:0] MD_SPDVAR = 4'h4;
    localparam logic [3:0] MD_SPDCMD = 4'h5;
    localparam logic [3:0] MD_POSDEV = 4'h6;
    localparam logic [3:0] MD_POSCMD = 4'h7;
    localparam logic [3:0] MD_INPOS  = 4'h8;
    localparam logic [3:0] MD_SPDFB  = 4'h9;
    localparam logic [3:0] MD_CMDSPD = 4'hA;
    localparam int CTRL_MODE_LSB = 0;
    localparam int CTRL_FUNC_BIT = 2;
endpackage

// file: verilog/ggss_top.sv
// gain group switch selector: group 1 or 2 choice for the loop regulators
// assumes one 250 MHz clock, an apb master and synchronous motion inputs
//
// What this block does
// - mode 6: position deviation drives group choice
// - mode 7: nonzero position instruction picks group 2
// - mode 8: incomplete positioning picks group 2
// - mode 9: speed feedback drives group choice
// - mode 10: instruction and speed gate return
// - position delay, grade, hysteresis, time ranges
// - codes 0 and 1 fix groups
// - code 2 follows external gain-select input
// - speed mode 3: torque instruction threshold
// - speed mode 4: speed instruction variation threshold
// - speed mode 5: speed instruction threshold
// - speed settings ranges, default zero
// - torque mode 3: torque instruction threshold
// - torque settings ranges, default zero
// - observer cutoff 0..500, applied on restart
// - phase compensation 0..10000, immediate
// - position mode 3: torque instruction threshold
`timescale 1ns/1ns
module ggss_top
(
    input  wire logic                    clk,
    input  wire logic                    rst,
    input  wire logic                    ce,
    input  wire logic                    psel,
    input  wire logic                    penable,
    input  wire logic                    pwrite,
    input  wire logic [7:0]              paddr,
    input  wire logic [31:0]             pwdata,
    output logic                         pready,
    output logic [31:0]                  prdata,
    output logic                         pslverr,
    input  wire logic                    restart,
    input  wire logic                    gain_sel_in,
    input  wire logic [15:0]             torque_cmd,
    input  wire logic [15:0]             speed_cmd,
    input  wire logic [15:0]             speed_cmd_var,
    input  wire logic [15:0]             speed_fb,
    input  wire logic [15:0]             pos_cmd,
    input  wire logic [15:0]             pos_dev,
    input  wire logic                    pos_done,
    output logic                         group2_sel,
    output logic                         pi_switch,
    output logic [1:0]                   obs_enable,
    output logic [15:0]                  obs_cutoff,
    output logic [15:0]                  obs_phase,
    output logic [15:0]                  obs_inertia
);
    import ggss_pkg::*;

    // ------------------------------------------------------------
    // register file
    // ------------------------------------------------------------
    logic [15:0] cfg_reg [NREG];
    logic [15:0] wr_val;
    logic [4:0]  wr_idx;
    wire  logic  acc       = psel & penable & ce;
    wire  logic  in_map    = (paddr[1:0] == 2'b00) && (paddr <= OFF_ACTIVE);
    wire  logic  ro_addr   = (paddr == OFF_STATUS) || (paddr == OFF_ACTIVE);
    wire  logic  wr_ok     = acc & pwrite & in_map & ~ro_addr;
    wire  logic  bad       = ~in_map | (pwrite & ro_addr);
    assign wr_idx = paddr[6:2];
    assign wr_val = pwdata[15:0];

    // clamp a write to the documented range of its register
    function automatic logic [15:0] clamp(input logic [4:0] idx, input logic [15:0] v);
        logic [15:0] lim;
        lim = 16'hFFFF;
        if (idx == OFF_POS_DELAY[6:2] || idx == OFF_POS_TIME[6:2]) lim = MAX_DELAY;
        if (idx == OFF_POS_GRADE[6:2] || idx == OFF_POS_HYST[6:2]) lim = MAX_GRADE;
        if (idx == OFF_POS_MODE[6:2]) lim = MAX_POS_MODE;
        if (idx == OFF_SPD_MODE[6:2]) lim = MAX_SPD_MODE;
        if (idx == OFF_SPD_DELAY[6:2]) lim = MAX_DELAY;
        if (idx == OFF_SPD_GRADE[6:2] || idx == OFF_SPD_HYST[6:2]) lim = MAX_GRADE;
        if (idx == OFF_TRQ_MODE[6:2]) lim = MAX_TRQ_MODE;
        if (idx == OFF_TRQ_DELAY[6:2]) lim = MAX_DELAY;
        if (idx == OFF_TRQ_GRADE[6:2] || idx == OFF_TRQ_HYST[6:2]) lim = MAX_GRADE;
        if (idx == OFF_OBS_EN[6:2]) lim = MAX_OBS_EN;
        if (idx == OFF_OBS_CUT[6:2]) lim = MAX_OBS_CUT;
        if (idx == OFF_OBS_PHASE[6:2]) lim = MAX_OBS_PHASE;
        if (idx == OFF_OBS_INERT[6:2]) lim = MAX_OBS_INERT;
        clamp = (v > lim) ? lim : v;
    endfunction

    // reset value of each register
    function automatic logic [15:0] rst_val(input int i);
        logic [15:0] r;
        r = RST_ZERO;
        if (i == int'(OFF_POS_DELAY[6:2])) r = RST_POS_DELAY;
        if (i == int'(OFF_POS_GRADE[6:2])) r = RST_POS_GRADE;
        if (i == int'(OFF_POS_HYST[6:2]))  r = RST_POS_HYST;
        if (i == int'(OFF_POS_TIME[6:2]))  r = RST_POS_TIME;
        if (i == int'(OFF_OBS_CUT[6:2]))   r = RST_OBS_CUT;
        if (i == int'(OFF_OBS_INERT[6:2])) r = RST_OBS_INERT;
        rst_val = r;
    endfunction

    // one word per generate entry; writes land at once, but observer enable, cutoff and inertia reach their outputs only on restart
    // the status slot is never written (read-only decode), so it stays zero
    genvar gi;
    generate
        for (gi = 0; gi < NREG; gi++)
        begin : g_cfg
            always_ff @(posedge clk)
            begin
                if (rst)
                    cfg_reg[gi] <= rst_val(gi);
                else if (wr_ok && wr_idx == 5'(gi))
                    cfg_reg[gi] <= clamp(5'(gi), wr_val);
            end
        end
    endgenerate

    wire logic [3:0]  pos_mode  = cfg_reg[OFF_POS_MODE[6:2]][3:0];
    wire logic [15:0] pos_delay = cfg_reg[OFF_POS_DELAY[6:2]];
    wire logic [15:0] pos_grade = cfg_reg[OFF_POS_GRADE[6:2]];
    wire logic [15:0] pos_hyst  = cfg_reg[OFF_POS_HYST[6:2]];
    wire logic [3:0]  spd_mode  = cfg_reg[OFF_SPD_MODE[6:2]][3:0];
    wire logic [15:0] spd_delay = cfg_reg[OFF_SPD_DELAY[6:2]];
    wire logic [15:0] spd_grade = cfg_reg[OFF_SPD_GRADE[6:2]];
    wire logic [15:0] spd_hyst  = cfg_reg[OFF_SPD_HYST[6:2]];
    wire logic [3:0]  trq_mode  = cfg_reg[OFF_TRQ_MODE[6:2]][3:0];
    wire logic [15:0] trq_delay = cfg_reg[OFF_TRQ_DELAY[6:2]];
    wire logic [15:0] trq_grade = cfg_reg[OFF_TRQ_GRADE[6:2]];
    wire logic [15:0] trq_hyst  = cfg_reg[OFF_TRQ_HYST[6:2]];
    wire logic [15:0] ctrl_w    = cfg_reg[OFF_CTRL[6:2]];
    wire ggss_ctrl_mode_t cmode = ggss_ctrl_mode_t'(ctrl_w[CTRL_MODE_LSB +: 2]);
    wire logic        func_grp  = ctrl_w[CTRL_FUNC_BIT];

    // ------------------------------------------------------------
    // mode selection per control mode
    // ------------------------------------------------------------
    logic [3:0]  act_mode;
    logic [15:0] act_delay, act_grade, act_hyst, qty;
    always_comb
    begin
        act_mode  = pos_mode;
        act_delay = pos_delay;
        act_grade = pos_grade;
        act_hyst  = pos_hyst;
        if (cmode == GGSS_CM_SPD)
        begin
            act_mode  = spd_mode;
            act_delay = spd_delay;
            act_grade = spd_grade;
            act_hyst  = spd_hyst;
        end
        else if (cmode == GGSS_CM_TRQ)
        begin
            act_mode  = trq_mode;
            act_delay = trq_delay;
            act_grade = trq_grade;
            act_hyst  = trq_hyst;
        end
    end

    // monitored quantity by mode code
    always_comb
    begin
        qty = 16'h0000;
        unique case (act_mode)
            // torque instruction in every control mode
            MD_TORQUE: qty = torque_cmd;
            MD_SPDVAR: qty = speed_cmd_var;
            MD_SPDCMD: qty = speed_cmd;
            MD_POSDEV: qty = pos_dev;
            MD_SPDFB:  qty = speed_fb;
            default:   qty = 16'h0000;
        endcase
    end

    // ------------------------------------------------------------
    // demand for group 2 and release condition
    // ------------------------------------------------------------
    // enter above grade, release only below grade minus hysteresis
    wire logic [16:0] low_mark  = {1'b0, act_grade} - {1'b0, act_hyst};
    wire logic        above     = qty > act_grade;
    wire logic        below     = low_mark[16] ? 1'b0 : ({1'b0, qty} < low_mark);
    wire logic        cmd_nz    = pos_cmd != 16'h0000;
    logic             want2, release_ok, fixed, fixed_val;
    always_comb
    begin
        want2      = 1'b0;
        release_ok = 1'b0;
        fixed      = 1'b0;
        fixed_val  = 1'b0;
        unique case (act_mode)
            MD_FIX1:   begin fixed = 1'b1; fixed_val = 1'b0; end
            MD_FIX2:   begin fixed = 1'b1; fixed_val = 1'b1; end
            // external input selects group when so configured
            MD_INPUT:  begin fixed = 1'b1; fixed_val = func_grp & gain_sel_in; end
            MD_POSCMD: begin want2 = cmd_nz; release_ok = ~cmd_nz; end
            MD_INPOS:  begin want2 = ~pos_done; release_ok = pos_done; end
            MD_CMDSPD: begin want2 = cmd_nz; release_ok = ~cmd_nz & (speed_fb < act_grade); end
            MD_TORQUE, MD_SPDVAR, MD_SPDCMD, MD_POSDEV, MD_SPDFB:
                       begin want2 = above; release_ok = below; end
            default:   begin fixed = 1'b1; fixed_val = 1'b0; end
        endcase
    end

    // ------------------------------------------------------------
    // return delay: steps of 0.1 ms
    // ------------------------------------------------------------
    logic [16:0] tick_reg;
    logic [15:0] steps_reg;
    logic        grp_reg;
    wire  logic  tick_end  = tick_reg == 17'(TICK_CYCLES - 1);
    wire  logic  delay_out = steps_reg >= act_delay;
    // delay restarts whenever release condition drops
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            tick_reg  <= '0;
            steps_reg <= '0;
            grp_reg   <= 1'b0;
        end
        else if (ce)
        begin
            if (fixed)
            begin
                grp_reg   <= fixed_val;
                tick_reg  <= '0;
                steps_reg <= '0;
            end
            else if (want2 || !grp_reg || !release_ok)
            begin
                grp_reg   <= grp_reg | want2;
                tick_reg  <= '0;
                steps_reg <= '0;
            end
            else if (delay_out)
                grp_reg <= 1'b0;
            else if (tick_end)
            begin
                tick_reg  <= '0;
                steps_reg <= steps_reg + 16'h0001;
            end
            else
                tick_reg <= tick_reg + 17'h00001;
        end
    end

    // ------------------------------------------------------------
    // outputs and restart-latched observer settings
    // ------------------------------------------------------------
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            group2_sel  <= 1'b0;
            pi_switch   <= 1'b0;
            obs_enable  <= 2'b00;
            obs_cutoff  <= RST_OBS_CUT;
            obs_phase   <= RST_ZERO;
            obs_inertia <= RST_OBS_INERT;
        end
        else if (ce)
        begin
            group2_sel <= grp_reg;
            // p/pi switch use of the input
            pi_switch  <= (act_mode == MD_INPUT) & ~func_grp & gain_sel_in;
            obs_phase  <= cfg_reg[OFF_OBS_PHASE[6:2]];
            if (restart)
            begin
                obs_enable  <= cfg_reg[OFF_OBS_EN[6:2]][1:0];
                obs_cutoff  <= cfg_reg[OFF_OBS_CUT[6:2]];
                obs_inertia <= cfg_reg[OFF_OBS_INERT[6:2]];
            end
        end
    end

    // ------------------------------------------------------------
    // apb answer: one access cycle, zero wait states
    // ------------------------------------------------------------
    wire logic [15:0] rd_word = (paddr == OFF_STATUS) ? {13'h0000, act_mode[2:0]} :
                                (paddr == OFF_ACTIVE) ? {15'h0000, grp_reg} :
                                in_map ? cfg_reg[wr_idx] : 16'h0000;
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            pready  <= 1'b0;
            prdata  <= 32'h00000000;
            pslverr <= 1'b0;
        end
        else if (ce)
        begin
            pready  <= psel & ~penable & ~pready;
            pslverr <= psel & ~penable & bad;
            prdata  <= {16'h0000, rd_word};
        end
    end
    // note: pready is registered off the setup cycle, so the access phase is one cycle

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    a_fixed_one: assert property (@(posedge clk) disable iff (rst)
        ce && act_mode == MD_FIX1 && cmode == GGSS_CM_POS ##1 ce |=> !group2_sel)
        else $error("fixed group 1 not held");
    a_want_enter: assert property (@(posedge clk) disable iff (rst)
        ce && !fixed && want2 |=> grp_reg)
        else $error("group 2 not entered");
    a_no_early_ret: assert property (@(posedge clk) disable iff (rst)
        grp_reg && !delay_out && !fixed |=> grp_reg)
        else $error("group 1 returned before delay");
    a_poscmd_hold: assert property (@(posedge clk) disable iff (rst)
        ce && act_mode == MD_POSCMD && cmd_nz |=> grp_reg)
        else $error("nonzero instruction left group 1");
    a_inpos_hold: assert property (@(posedge clk) disable iff (rst)
        ce && act_mode == MD_INPOS && !pos_done |=> grp_reg)
        else $error("incomplete positioning left group 1");
    a_input_sel: assert property (@(posedge clk) disable iff (rst)
        ce && act_mode == MD_INPUT && func_grp |=> grp_reg == $past(gain_sel_in))
        else $error("input select ignored");
    a_restart_only: assert property (@(posedge clk) disable iff (rst)
        !restart |=> $stable(obs_cutoff))
        else $error("cutoff changed without restart");
    a_enable_rng: assert property (@(posedge clk) disable iff (rst)
        obs_enable != 2'b11)
        else $error("observer enable out of range");
    a_delay_rng: assert property (@(posedge clk) disable iff (rst)
        pos_delay <= MAX_DELAY && spd_delay <= MAX_DELAY)
        else $error("delay setting out of range");
    c_enter: cover property (@(posedge clk) !grp_reg ##1 grp_reg);
    c_return: cover property (@(posedge clk) grp_reg ##1 !grp_reg);
    c_restart: cover property (@(posedge clk) restart && ce);
endmodule // ggss_top

// file: dv/ggss_motion_model.sv
// far-side motion source: the quantities and gain-select input the selector watches
// assumes the bench picks one channel and its level by nba just after a clock edge
`timescale 1ns/1ns
module ggss_motion_model
(
    input  wire logic [2:0]  chan_sel,
    input  wire logic [15:0] chan_level,
    output logic [15:0]      torque_cmd,
    output logic [15:0]      speed_cmd,
    output logic [15:0]      speed_cmd_var,
    output logic [15:0]      speed_fb,
    output logic [15:0]      pos_cmd,
    output logic [15:0]      pos_dev,
    output logic             gain_sel_in,
    output logic             pos_done
);
    // ------------------------------------------------------------
    // channel steering
    // ------------------------------------------------------------
    // only the chosen quantity moves; the rest sit at zero, pos_done at one, like an idle axis
    assign torque_cmd    = (chan_sel == 3'h0) ? chan_level : 16'h0000;
    assign speed_cmd     = (chan_sel == 3'h1) ? chan_level : 16'h0000;
    assign speed_cmd_var = (chan_sel == 3'h2) ? chan_level : 16'h0000;
    assign speed_fb      = (chan_sel == 3'h3) ? chan_level : 16'h0000;
    assign pos_cmd       = (chan_sel == 3'h4) ? chan_level : 16'h0000;
    assign pos_dev       = (chan_sel == 3'h5) ? chan_level : 16'h0000;
    assign gain_sel_in   = (chan_sel == 3'h6) && (chan_level != 16'h0000);
    // complete unless channel 7 holds positioning off
    assign pos_done      = !((chan_sel == 3'h7) && (chan_level != 16'h0000));
endmodule // ggss_motion_model

// file: dv/gain_group_switch_selector_bench.sv
// bench for the selector: apb register tasks and group-switch sequences
// assumes ggss_top, ggss_pkg and the motion model are compiled before it
`timescale 1ns/1ns
`define CHK(got, exp) \
    begin \
        samples_checked++; \
        if ((got) !== (exp)) \
        begin \
            miscompares++; \
            $display("[FAIL] %0t got %h exp %h", $time, (got), (exp)); \
        end \
    end
module gain_group_switch_selector_bench;
    import ggss_pkg::*;
    logic        clk, rst, ce, psel, penable, pwrite, restart, pready, pslverr;
    logic        gain_sel_in, pos_done, group2_sel, pi_switch, rerr;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rdata;
    logic [15:0] torque_cmd, speed_cmd, speed_cmd_var, speed_fb, pos_cmd, pos_dev;
    logic [15:0] obs_cutoff, obs_phase, obs_inertia, chan_level;
    logic [1:0]  obs_enable;
    logic [2:0]  chan_sel;
    int          miscompares, samples_checked;
    logic [7:0]  roff [10] = '{OFF_POS_DELAY, OFF_POS_GRADE, OFF_POS_HYST, OFF_POS_TIME, OFF_SPD_MODE,
                               OFF_TRQ_HYST, OFF_OBS_EN, OFF_OBS_CUT, OFF_OBS_PHASE, OFF_OBS_INERT};
    logic [15:0] rval [10] = '{RST_POS_DELAY, RST_POS_GRADE, RST_POS_HYST, RST_POS_TIME, RST_ZERO,
                               RST_ZERO, RST_ZERO, RST_OBS_CUT, RST_ZERO, RST_OBS_INERT};

    // clock enable comes from the bench so one test can freeze the selector
    ggss_top dut (.clk(clk), .rst(rst), .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
        .restart(restart), .gain_sel_in(gain_sel_in), .torque_cmd(torque_cmd), .speed_cmd(speed_cmd),
        .speed_cmd_var(speed_cmd_var), .speed_fb(speed_fb), .pos_cmd(pos_cmd), .pos_dev(pos_dev),
        .pos_done(pos_done), .group2_sel(group2_sel), .pi_switch(pi_switch), .obs_enable(obs_enable),
        .obs_cutoff(obs_cutoff), .obs_phase(obs_phase), .obs_inertia(obs_inertia));
    ggss_motion_model far (.chan_sel(chan_sel), .chan_level(chan_level), .torque_cmd(torque_cmd),
        .speed_cmd(speed_cmd), .speed_cmd_var(speed_cmd_var), .speed_fb(speed_fb), .pos_cmd(pos_cmd),
        .pos_dev(pos_dev), .gain_sel_in(gain_sel_in), .pos_done(pos_done));

    // ------------------------------------------------------------
    // clock and watchdog
    // ------------------------------------------------------------
    initial
    begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    // the long return-delay test dominates: about 37000 cycles
    initial
    begin
        #(80000 * 4);
        miscompares++;
        final_report();
    end

    // ------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------
    // one apb transfer, entered just after an edge; idle edge after release avoids double nba
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        // no cycle count assumed: only the watchdog ends a hung wait
        do
            @(posedge clk);
        while (pready !== 1'b1);
        rdata = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask
    task automatic wr_rd(input logic [7:0] a, input logic [15:0] d, input logic [15:0] e);
        apb(1'b1, a, {16'h0000, d});
        apb(1'b0, a, 32'h0000_0000);
        `CHK(rdata, {16'h0000, e})
    endtask
    task automatic wait_cyc(input int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic drive(input logic [2:0] ch, input logic [15:0] lv);
        chan_sel <= ch;
        chan_level <= lv;
    endtask
    // demand on, then off with zero delay: group 2 then back to group 1
    task automatic run_switch(input logic [31:0] ctrl, input logic [7:0] moff, input logic [31:0] md,
                              input logic [2:0] ch);
        drive(ch, 16'h0000);
        apb(1'b1, OFF_CTRL, ctrl);
        apb(1'b1, moff, md);
        wait_cyc(6);
        `CHK(group2_sel, 1'b0)
        drive(ch, 16'h00C8);
        wait_cyc(6);
        `CHK(group2_sel, 1'b1)
        drive(ch, 16'h0000);
        wait_cyc(8);
        `CHK(group2_sel, 1'b0)
    endtask
    task automatic test_done(input string name);
        $display("test %s done, mismatches so far %0d", name, miscompares);
    endtask
    task automatic final_report();
        $display("checks %0d mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    // ------------------------------------------------------------
    // tests
    // ------------------------------------------------------------
    initial
    begin
        rst = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0000_0000;
        restart = 1'b0;
        ce = 1'b1;
        chan_sel = 3'h0;
        chan_level = 16'h0000;
        miscompares = 0;
        samples_checked = 0;
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        for (int i = 0; i < 10; i++)
        begin
            apb(1'b0, roff[i], 32'h0000_0000);
            `CHK(rdata, {16'h0000, rval[i]})
        end
        `CHK(obs_cutoff, RST_OBS_CUT)
        `CHK(obs_inertia, RST_OBS_INERT)
        test_done("reset values");
        apb(1'b0, 8'h50, 32'h0000_0000);
        `CHK({rerr, rdata}, 33'h1_0000_0000)
        apb(1'b1, OFF_STATUS, 32'h0000_0007);
        `CHK(rerr, 1'b1)
        wr_rd(OFF_POS_DELAY, 16'hFFFF, MAX_DELAY);
        wr_rd(OFF_SPD_GRADE, 16'hFFFF, MAX_GRADE);
        wr_rd(OFF_TRQ_MODE, 16'h0007, MAX_TRQ_MODE);
        wr_rd(OFF_OBS_CUT, 16'h0258, MAX_OBS_CUT);
        test_done("errors and ranges");
        wr_rd(OFF_OBS_CUT, 16'h00C8, 16'h00C8);
        wr_rd(OFF_OBS_EN, 16'h0002, 16'h0002);
        wr_rd(OFF_OBS_INERT, 16'h0400, 16'h0400);
        wr_rd(OFF_OBS_PHASE, 16'h0032, 16'h0032);
        wait_cyc(3);
        `CHK({obs_phase, obs_cutoff, obs_enable}, {16'h0032, RST_OBS_CUT, 2'h0})
        restart <= 1'b1;
        @(posedge clk);
        restart <= 1'b0;
        wait_cyc(3);
        `CHK({obs_cutoff, obs_enable, obs_inertia}, {16'h00C8, 2'h2, 16'h0400})
        test_done("observer");
        wr_rd(OFF_POS_DELAY, 16'h0000, 16'h0000);
        wr_rd(OFF_POS_GRADE, 16'h0064, 16'h0064);
        wr_rd(OFF_POS_HYST, 16'h000A, 16'h000A);
        wr_rd(OFF_SPD_GRADE, 16'h0064, 16'h0064);
        wr_rd(OFF_SPD_HYST, 16'h000A, 16'h000A);
        wr_rd(OFF_TRQ_GRADE, 16'h0064, 16'h0064);
        wr_rd(OFF_TRQ_HYST, 16'h000A, 16'h000A);
        apb(1'b1, OFF_CTRL, 32'h0000_0001);
        apb(1'b1, OFF_SPD_MODE, 32'h0000_0001);
        wait_cyc(6);
        `CHK(group2_sel, 1'b1)
        apb(1'b1, OFF_SPD_MODE, 32'h0000_0000);
        drive(3'h0, 16'h00C8);
        wait_cyc(6);
        `CHK(group2_sel, 1'b0)
        apb(1'b1, OFF_SPD_MODE, 32'h0000_0002);
        drive(3'h6, 16'h0001);
        wait_cyc(6);
        `CHK({group2_sel, pi_switch}, 2'b01)
        test_done("fixed codes and P/PI");
        run_switch(32'h0000_0000, OFF_POS_MODE, 32'h0000_0003, 3'h0);
        run_switch(32'h0000_0000, OFF_POS_MODE, 32'h0000_0006, 3'h5);
        run_switch(32'h0000_0000, OFF_POS_MODE, 32'h0000_0007, 3'h4);
        run_switch(32'h0000_0000, OFF_POS_MODE, 32'h0000_0008, 3'h7);
        run_switch(32'h0000_0000, OFF_POS_MODE, 32'h0000_0009, 3'h3);
        run_switch(32'h0000_0000, OFF_POS_MODE, 32'h0000_000A, 3'h4);
        run_switch(32'h0000_0005, OFF_SPD_MODE, 32'h0000_0002, 3'h6);
        run_switch(32'h0000_0001, OFF_SPD_MODE, 32'h0000_0003, 3'h0);
        run_switch(32'h0000_0001, OFF_SPD_MODE, 32'h0000_0004, 3'h2);
        run_switch(32'h0000_0001, OFF_SPD_MODE, 32'h0000_0005, 3'h1);
        run_switch(32'h0000_0002, OFF_TRQ_MODE, 32'h0000_0003, 3'h0);
        test_done("switch modes");
        apb(1'b1, OFF_CTRL, 32'h0000_0001);
        apb(1'b1, OFF_SPD_MODE, 32'h0000_0003);
        apb(1'b1, OFF_SPD_HYST, 32'h0000_0014);
        apb(1'b1, OFF_SPD_DELAY, 32'h0000_0001);
        ce <= 1'b0;
        drive(3'h0, 16'h0096);
        wait_cyc(6);
        `CHK(group2_sel, 1'b0)
        ce <= 1'b1;
        wait_cyc(6);
        `CHK(group2_sel, 1'b1)
        apb(1'b0, OFF_STATUS, 32'h0000_0000);
        `CHK(rdata, 32'h0000_0003)
        apb(1'b0, OFF_ACTIVE, 32'h0000_0000);
        `CHK(rdata, 32'h0000_0001)
        drive(3'h0, 16'h005A);
        wait_cyc(40);
        `CHK(group2_sel, 1'b1)
        drive(3'h0, 16'h0032);
        wait_cyc(12000);
        drive(3'h0, 16'h0096);
        wait_cyc(5);
        drive(3'h0, 16'h0032);
        wait_cyc(TICK_CYCLES - 10);
        `CHK(group2_sel, 1'b1)
        wait_cyc(40);
        `CHK(group2_sel, 1'b0)
        test_done("hysteresis and delay");
        final_report();
    end
endmodule // gain_group_switch_selector_bench
